// ==== pkg/host_bus_pkg.sv ====
// Constants for the host bus and pin control block
package host_bus_pkg;
   localparam int        ADDR_W          = 7;
   localparam int        DATA_W          = 8;
   localparam int        PORTA_W         = 8;
   localparam int        PORTB_W         = 5;
   localparam int        IRQ_SRC_W       = 11;
   // Transfer acknowledge needs two clock edges after chip select
   localparam int        ACK_EDGES       = 2;
   localparam logic [1:0] ACK_CNT_MAX    = 2'h2;
   // Address decode
   localparam logic [6:0] LOW_SPACE_MASK = 7'h70;
   localparam logic [6:0] ADDR_OPR       = 7'h20;
   localparam logic [6:0] ADDR_OUTPUT_PORT_CONFIG      = 7'h21;
   localparam logic [6:0] ADDR_PFC       = 7'h22;
   localparam logic [6:0] ADDR_IMR       = 7'h23;
   localparam logic [6:0] ADDR_ISR       = 7'h24;
   localparam logic [6:0] ADDR_SR        = 7'h25;
   localparam logic [6:0] ADDR_MODE1     = 7'h26;
   localparam logic [6:0] ADDR_PORTA_IN  = 7'h27;
   localparam logic [6:0] ADDR_PORTB_IN  = 7'h28;
   localparam logic [6:0] ADDR_BUSCFG    = 7'h29;
   localparam logic [6:0] ADDR_VECTOR    = 7'h2a;
   // Reset values
   localparam logic [7:0] MODE1_RESET    = 8'h13;   // 8 data bits, no parity
   localparam logic [7:0] BAUD_RESET     = 8'h0b;   // Index of 9600 baud
   localparam logic [7:0] VECTOR_RESET   = 8'h0f;
   localparam logic [7:0] ZERO8          = 8'h00;
   // INTERRUPT_STATUS_REGISTER bit positions for change of state
   localparam int        ISR_COS_A       = 0;
   localparam int        ISR_COS_B       = 1;
   typedef enum logic { BUS_STROBE, BUS_RW } bus_style_t;
   typedef enum { BUS_IDLE, BUS_WAIT, BUS_ACK } bus_state_t;
endpackage

// ==== rtl/host_bus_ctrl.sv ====
// Host parallel bus interface and pin control of a single UART channel
`timescale 1ns/1ps
module host_bus_ctrl (
   // Clock and reset
   input  wire logic                                mclk,
   input  wire logic                                reset,
   // Host bus
   input  wire logic                                chip_select_n,
   input  wire logic                                read_write_select,
   input  wire logic                                interrupt_ack_n,
   input  wire logic [host_bus_pkg::ADDR_W-1:0]     register_select_lines,
   input  wire logic                                bus_style_select,
   input  wire logic [host_bus_pkg::DATA_W-1:0]     data_in,
   output logic      [host_bus_pkg::DATA_W-1:0]     data_out,
   output logic                                     data_oe_n,
   output logic                                     transfer_ack_n,
   output logic                                     transfer_ack_oe_n,
   output logic                                     interrupt_request_n,
   output logic                                     interrupt_request_oe_n,
   // Internal sources
   input  wire logic [host_bus_pkg::IRQ_SRC_W-1:0]  irq_sources,
   input  wire logic                                receive_ready_flag,
   input  wire logic                                transmit_ready_flag,
   input  wire logic                                timer_ready_flag,
   input  wire logic                                tx_serial_bit,
   input  wire logic                                tx_active,
   input  wire logic                                tx_enable,
   input  wire logic                                local_loopback,
   // Serial pins
   input  wire logic                                rx_pin,
   output logic                                     tx_pin,
   output logic                                     rx_bit,
   // Port pins
   input  wire logic [host_bus_pkg::PORTA_W-1:0]    port_a_pins_in,
   output logic      [host_bus_pkg::PORTA_W-1:0]    port_a_pins_out,
   output logic      [host_bus_pkg::PORTA_W-1:0]    port_a_pins_oe_n,
   input  wire logic [host_bus_pkg::PORTB_W-1:0]    port_b_pins_in,
   output logic      [host_bus_pkg::PORTB_W-1:0]    port_b_pins_out,
   output logic      [host_bus_pkg::PORTB_W-1:0]    port_b_pins_oe_n,
   // Status to the channel
   output logic                                     timer_run,
   output logic                                     channel_active,
   output logic      [7:0]                          mode_first_q_out,
   output logic      [7:0]                          baud_sel_out,
   output logic                                     mode_pointer_out
);
   import host_bus_pkg::*;

   // Synchronisers for all pins
   logic [ADDR_W-1:0]  addr_s1, addr_s2;
   logic [DATA_W-1:0]  din_s1, din_s2;
   logic [2:0]         ctl_s1, ctl_s2;
   logic               style_s1, style_s2, rx_s1, rx_s2;
   logic [PORTA_W-1:0] pa_s1, pa_s2, pa_prev_q;
   logic [PORTB_W-1:0] pb_s1, pb_s2, pb_prev_q;

   always_ff @(posedge mclk) begin
      addr_s1  <= register_select_lines;
      addr_s2  <= addr_s1;
      din_s1   <= data_in;
      din_s2   <= din_s1;
      ctl_s1   <= {chip_select_n, read_write_select, interrupt_ack_n};
      ctl_s2   <= ctl_s1;
      style_s1 <= bus_style_select;
      style_s2 <= style_s1;
      rx_s1    <= rx_pin;
      rx_s2    <= rx_s1;
      pa_s1    <= port_a_pins_in;
      pa_s2    <= pa_s1;
      pb_s1    <= port_b_pins_in;
      pb_s2    <= pb_s1;
   end

   logic cs_act, rd, iack_act;
   assign cs_act   = ~ctl_s2[2];
   assign rd       = ctl_s2[1];
   assign iack_act = ~ctl_s2[0];

   // Bus cycle sequencer
   bus_state_t state_q;
   logic [1:0] edge_cnt_q;
   logic       cycle_live, take_q;
   assign cycle_live = cs_act | iack_act;

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q    <= BUS_IDLE;
         edge_cnt_q <= 2'h0;
      end else begin
         case (state_q)
            BUS_IDLE: begin
               edge_cnt_q <= 2'h0;
               if (cycle_live) begin
                  state_q    <= BUS_WAIT;
                  edge_cnt_q <= 2'h1;
               end
            end
            BUS_WAIT: begin
               if (!cycle_live) begin
                  state_q <= BUS_IDLE;
               end else if (edge_cnt_q >= ACK_CNT_MAX[1:0] - 2'h1) begin
                  state_q <= BUS_ACK;
               end else begin
                  edge_cnt_q <= edge_cnt_q + 2'h1;
               end
            end
            BUS_ACK: begin
               if (!cycle_live) begin
                  state_q <= BUS_IDLE;
               end
            end
            default: state_q <= BUS_IDLE;
         endcase
      end
   end

   assign take_q = (state_q == BUS_WAIT) && cycle_live && (edge_cnt_q >= ACK_CNT_MAX - 2'h1);

   // Registers
   logic [7:0] opr_q, output_port_config_q, pfc_q, imr_q, isr_q, sr_q, mode1_q, baud_q, vector_q;
   logic       mode_ptr_q, style_reg_q, style_force_q;
   logic       low_space, wr_take;
   logic [1:0] cos_hit;
   assign low_space = (addr_s2 & LOW_SPACE_MASK) == 7'h00;
   assign wr_take   = take_q && cs_act && !iack_act && !rd;
   assign cos_hit   = {|(pb_s2 ^ pb_prev_q), |(pa_s2 ^ pa_prev_q)};

   always_ff @(posedge mclk) begin
      pa_prev_q <= pa_s2;
      pb_prev_q <= pb_s2;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         opr_q         <= ZERO8;
         output_port_config_q        <= ZERO8;
         pfc_q         <= ZERO8;
         imr_q         <= ZERO8;
         sr_q          <= ZERO8;
         mode1_q       <= MODE1_RESET;
         baud_q        <= BAUD_RESET;
         vector_q      <= VECTOR_RESET;
         mode_ptr_q    <= 1'b0;
         style_reg_q   <= 1'b0;
         style_force_q <= 1'b0;
      end else if (wr_take) begin
         case (addr_s2)
            ADDR_OPR:    opr_q  <= din_s2;
            ADDR_OUTPUT_PORT_CONFIG:   output_port_config_q <= din_s2;
            ADDR_PFC:    pfc_q  <= din_s2;
            ADDR_IMR:    imr_q  <= din_s2;
            ADDR_SR:     sr_q   <= din_s2;
            ADDR_VECTOR: vector_q <= din_s2;
            ADDR_MODE1: begin
               mode1_q    <= din_s2;
               mode_ptr_q <= 1'b1;
            end
            ADDR_BUSCFG: begin
               style_force_q <= din_s2[1];
               style_reg_q   <= din_s2[0];
            end
            default: ;
         endcase
      end
   end

   // Change of state sets win over write-one-to-clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         isr_q <= ZERO8;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cos_hit[i]) begin
               isr_q[i] <= 1'b1;
            end else if (wr_take && addr_s2 == ADDR_ISR && din_s2[i]) begin
               isr_q[i] <= 1'b0;
            end
         end
      end
   end

   bus_style_t style;
   assign style = (style_force_q ? style_reg_q : ~style_s2) ? BUS_RW : BUS_STROBE;

   // Read data and acknowledge
   logic [7:0] rd_mux;
   always_comb begin
      case (addr_s2)
         ADDR_OPR:      rd_mux = opr_q;
         ADDR_OUTPUT_PORT_CONFIG:     rd_mux = output_port_config_q;
         ADDR_PFC:      rd_mux = pfc_q;
         ADDR_IMR:      rd_mux = imr_q;
         ADDR_ISR:      rd_mux = isr_q;
         ADDR_SR:       rd_mux = sr_q;
         ADDR_MODE1:    rd_mux = mode1_q;
         ADDR_PORTA_IN: rd_mux = pa_s2;
         ADDR_PORTB_IN: rd_mux = {3'h0, pb_s2};
         ADDR_BUSCFG:   rd_mux = {6'h00, style_force_q, style == BUS_RW};
         ADDR_VECTOR:   rd_mux = vector_q;
         default:       rd_mux = ZERO8;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         data_out          <= ZERO8;
         data_oe_n         <= 1'b1;
         transfer_ack_n    <= 1'b0;
         transfer_ack_oe_n <= 1'b1;
      end else begin
         if (take_q) begin
            data_out <= iack_act ? vector_q : rd_mux;
         end
         data_oe_n         <= ~((take_q || state_q == BUS_ACK) && cycle_live && (iack_act || rd));
         transfer_ack_n    <= 1'b0;
         transfer_ack_oe_n <= ~((take_q || state_q == BUS_ACK) && cycle_live);
      end
   end

   // Interrupt request
   logic [IRQ_SRC_W-1:0] irq_en;
   assign irq_en = {imr_q[7:2], 3'h0, 2'h0} | {{(IRQ_SRC_W-2){1'b0}}, imr_q[1:0]};
   always_ff @(posedge mclk) begin
      if (reset) begin
         interrupt_request_n    <= 1'b0;
         interrupt_request_oe_n <= 1'b1;
      end else begin
         interrupt_request_n    <= 1'b0;
         interrupt_request_oe_n <= ~(|((irq_sources | {9'h000, isr_q[1:0]}) & irq_en));
      end
   end

   // Port pins; output_port_config bit enables output, pfc bit routes ready flags to port A
   logic any_ready;
   assign any_ready = receive_ready_flag | transmit_ready_flag | timer_ready_flag;
   always_ff @(posedge mclk) begin
      if (reset) begin
         port_a_pins_out  <= ZERO8;
         port_a_pins_oe_n <= 8'hff;
         port_b_pins_out  <= 5'h00;
         port_b_pins_oe_n <= 5'h1f;
      end else begin
         port_b_pins_out  <= opr_q[PORTB_W-1:0];
         port_b_pins_oe_n <= ~output_port_config_q[PORTB_W-1:0];
         for (int i = 0; i < PORTA_W; i++) begin
            if (low_space && cycle_live) begin
               port_a_pins_oe_n[i] <= 1'b1;
               port_a_pins_out[i]  <= 1'b0;
            end else if (pfc_q[i]) begin
               port_a_pins_out[i]  <= 1'b0;   // Open drain: only pull low
               port_a_pins_oe_n[i] <= ~(output_port_config_q[i] & any_ready);
            end else begin
               port_a_pins_out[i]  <= opr_q[i];
               port_a_pins_oe_n[i] <= ~output_port_config_q[i];
            end
         end
      end
   end

   // Serial line and channel state
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_pin           <= 1'b1;
         rx_bit           <= 1'b1;
         timer_run        <= 1'b0;
         channel_active   <= 1'b0;
         mode_first_q_out <= MODE1_RESET;
         baud_sel_out     <= BAUD_RESET;
         mode_pointer_out <= 1'b0;
      end else begin
         tx_pin           <= (tx_enable && tx_active && !local_loopback) ? tx_serial_bit : 1'b1;
         rx_bit           <= rx_s2;   // High is mark
         timer_run        <= sr_q[0];
         channel_active   <= tx_enable;
         mode_first_q_out <= mode1_q;
         baud_sel_out     <= baud_q;
         mode_pointer_out <= mode_ptr_q;
      end
   end
endmodule // host_bus_ctrl

// ==== testbench/host_bus_ctrl_asserts.sv ====
// Port-level checks of the host bus controller
`timescale 1ns/1ps
module host_bus_ctrl_asserts
   import host_bus_pkg::*;
(
   input wire logic              mclk, reset, chip_select_n, interrupt_ack_n,
   input wire logic [ADDR_W-1:0] register_select_lines,
   input wire logic              data_oe_n, transfer_ack_n, transfer_ack_oe_n,
   input wire logic              interrupt_request_n, interrupt_request_oe_n,
   input wire logic              tx_serial_bit, tx_active, tx_enable, local_loopback,
   input wire logic              rx_pin, tx_pin, rx_bit, timer_run, mode_pointer_out,
   input wire logic [7:0]        port_a_pins_oe_n, baud_sel_out,
   input wire logic [4:0]        port_b_pins_oe_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_ack_not_early: assert property ($fell(transfer_ack_oe_n) |->
      !$past(chip_select_n, 3) || !$past(interrupt_ack_n, 3)) else $error("ack too early");
   a_ack_release: assert property ((chip_select_n && interrupt_ack_n) [*6] |->
      transfer_ack_oe_n) else $error("ack not released");
   a_od_low: assert property (!transfer_ack_n && !interrupt_request_n)
      else $error("open drain output not low");
   a_data_float: assert property ((chip_select_n && interrupt_ack_n) [*6] |->
      data_oe_n) else $error("data bus driven while idle");
   a_reset_state: assert property ($fell(reset) |-> tx_pin && &port_a_pins_oe_n
      && &port_b_pins_oe_n && interrupt_request_oe_n && !timer_run && !mode_pointer_out
      && baud_sel_out == BAUD_RESET) else $error("bad state after reset");
   a_tx_idle_mark: assert property ((!tx_enable || !tx_active || local_loopback) |=> tx_pin)
      else $error("transmit not at mark");
   a_tx_bit_out: assert property ((tx_enable && tx_active && !local_loopback) |=>
      tx_pin == $past(tx_serial_bit)) else $error("transmit bit lost");
   a_rx_follow: assert property ($stable(rx_pin) [*5] |-> rx_bit == rx_pin)
      else $error("receive bit wrong");
   a_low_space: assert property ((!chip_select_n && register_select_lines[6:4] == 3'h0) [*5] |->
      &port_a_pins_oe_n) else $error("port A driven in low space");
   c_iack: cover property ($fell(transfer_ack_oe_n) && !interrupt_ack_n);
   c_irq: cover property ($fell(interrupt_request_oe_n));
   c_tx: cover property ($fell(tx_pin));
endmodule // host_bus_ctrl_asserts

// ==== testbench/host_model.sv ====
// Behavioural host processor on the parallel bus
`timescale 1ns/1ps
module host_model
   import host_bus_pkg::*;
(
   input  wire logic              mclk, transfer_ack_oe_n, data_oe_n,
   input  wire logic [DATA_W-1:0] data_out,
   output logic                   chip_select_n, read_write_select, interrupt_ack_n, bus_style_select,
   output logic [ADDR_W-1:0]      register_select_lines,
   output logic [DATA_W-1:0]      data_in
);
   initial begin
      chip_select_n = 1'b1;
      interrupt_ack_n = 1'b1;
      read_write_select = 1'b1;
      register_select_lines = 7'h7f;
      data_in = 8'h5a;
      bus_style_select = 1'b1; // Separate strobe format
   end
   task automatic cycle(input logic rd, ia, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
      int n;
      @(posedge mclk);
      if (ia) interrupt_ack_n <= 1'b0;
      else begin
         chip_select_n <= 1'b0;
         read_write_select <= rd;
         register_select_lines <= a;
         if (!rd) data_in <= d;
      end
      n = 0;
      ok = 1'b0;
      while (n < 64 && !ok) begin
         @(posedge mclk);
         ok = (transfer_ack_oe_n === 1'b0);
         n++;
      end
      // Undriven bus reads back as garbage, never the last value
      q = (data_oe_n === 1'b0) ? data_out : ~data_out;
      chip_select_n <= 1'b1;
      interrupt_ack_n <= 1'b1;
      register_select_lines <= ~a;
      data_in <= ~d;
      n = 0;
      while (n < 64 && transfer_ack_oe_n !== 1'b1) begin
         @(posedge mclk);
         n++;
      end
      ok = ok && (transfer_ack_oe_n === 1'b1);
   endtask
endmodule // host_model

// ==== testbench/tb_top.sv ====
// Self-checking bench of the host bus controller
`timescale 1ns/1ps
module tb_top;
   import host_bus_pkg::*;
   logic        mclk, reset, chip_select_n, read_write_select, interrupt_ack_n, bus_style_select;
   logic        data_oe_n, transfer_ack_n, transfer_ack_oe_n, interrupt_request_n, interrupt_request_oe_n;
   logic        tx_serial_bit, tx_active, tx_enable, local_loopback, rx_pin, tx_pin, rx_bit;
   logic        timer_run, channel_active, mode_pointer_out;
   logic        receive_ready_flag, transmit_ready_flag, timer_ready_flag;
   logic [6:0]  register_select_lines;
   logic [7:0]  data_in, data_out, port_a_pins_in, port_a_pins_out, port_a_pins_oe_n;
   logic [7:0]  mode_first_q_out, baud_sel_out;
   logic [4:0]  port_b_pins_in, port_b_pins_out, port_b_pins_oe_n;
   logic [10:0] irq_sources;
   int          errors, checks;
   host_bus_ctrl i_host_bus_ctrl (.mclk, .reset, .chip_select_n, .read_write_select, .interrupt_ack_n,
      .register_select_lines, .bus_style_select, .data_in, .data_out, .data_oe_n, .transfer_ack_n,
      .transfer_ack_oe_n, .interrupt_request_n, .interrupt_request_oe_n, .irq_sources,
      .receive_ready_flag, .transmit_ready_flag, .timer_ready_flag, .tx_serial_bit,
      .tx_active, .tx_enable, .local_loopback, .rx_pin, .tx_pin, .rx_bit, .port_a_pins_in,
      .port_a_pins_out, .port_a_pins_oe_n, .port_b_pins_in, .port_b_pins_out, .port_b_pins_oe_n,
      .timer_run, .channel_active, .mode_first_q_out, .baud_sel_out, .mode_pointer_out);
   host_model i_host_model (.mclk, .transfer_ack_oe_n, .data_oe_n, .data_out, .chip_select_n,
      .read_write_select, .interrupt_ack_n, .bus_style_select, .register_select_lines, .data_in);
   task automatic chk(input logic [7:0] got, exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic bus(input logic rd, ia, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      logic ok;
      i_host_model.cycle(rd, ia, a, d, q, ok);
      if (!ok) begin
         errors++;
         summarize();
      end
   endtask
   task automatic t_reset;
      logic [7:0] q;
      logic [6:0] a [5] = '{ADDR_SR, ADDR_IMR, ADDR_ISR, ADDR_OPR, ADDR_OUTPUT_PORT_CONFIG};
      chk({7'h0, tx_pin}, 8'h01);
      chk(mode_first_q_out, MODE1_RESET);
      chk(port_a_pins_oe_n, 8'hff);
      chk({3'h0, port_b_pins_oe_n}, 8'h1f);
      chk({7'h0, timer_run}, 8'h00);
      chk({7'h0, mode_pointer_out}, 8'h00);
      chk(baud_sel_out, BAUD_RESET);
      chk({7'h0, interrupt_request_oe_n}, 8'h01);
      foreach (a[i]) begin
         bus(1'b1, 1'b0, a[i], 8'h00, q);
         chk(q, ZERO8);
      end
   endtask
   task automatic t_regs;
      logic [7:0] q;
      logic [6:0] a [5] = '{ADDR_OPR, ADDR_VECTOR, ADDR_MODE1, ADDR_SR, 7'h7f};
      logic [7:0] e [5] = '{8'h3c, 8'h96, 8'h27, 8'h01, 8'h00};
      foreach (a[i]) bus(1'b0, 1'b0, a[i], i == 4 ? 8'hff : e[i], q);
      foreach (a[i]) begin
         bus(1'b1, 1'b0, a[i], 8'h00, q);
         chk(q, e[i]);
      end
      bus(1'b1, 1'b1, 7'h00, 8'h00, q);
      chk(q, 8'h96);
      bus(1'b1, 1'b0, ADDR_BUSCFG, 8'h00, q);
      chk(q, 8'h00);
      bus(1'b0, 1'b0, ADDR_BUSCFG, 8'h03, q);
      bus(1'b1, 1'b0, ADDR_BUSCFG, 8'h00, q);
      chk(q, 8'h03);
   endtask
   task automatic t_irq;
      logic [7:0] q;
      int n;
      @(posedge mclk);
      irq_sources <= 11'h020;
      repeat (8) @(posedge mclk);
      chk({7'h0, interrupt_request_oe_n}, 8'h01);
      bus(1'b0, 1'b0, ADDR_IMR, 8'h04, q);
      repeat (8) @(posedge mclk);
      chk({7'h0, interrupt_request_oe_n}, 8'h00);
      irq_sources <= 11'h000;
      bus(1'b0, 1'b0, ADDR_IMR, 8'h02, q);
      port_b_pins_in <= 5'h0a;
      n = 0;
      while (n < 20000 && interrupt_request_oe_n !== 1'b0) begin
         @(posedge mclk);
         n++;
      end
      chk({7'h0, interrupt_request_oe_n}, 8'h00);
      bus(1'b1, 1'b0, ADDR_ISR, 8'h00, q);
      chk(q, 8'h02);
      bus(1'b0, 1'b0, ADDR_ISR, 8'h02, q);
      bus(1'b1, 1'b0, ADDR_ISR, 8'h00, q);
      chk(q & 8'h02, 8'h00);
      repeat (4) @(posedge mclk);
      chk({7'h0, interrupt_request_oe_n}, 8'h01);
   endtask
   task automatic t_tx;
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         {tx_enable, tx_active, local_loopback} <= i[2:0];
         repeat (4) @(posedge mclk);
         chk({7'h0, tx_pin}, (i == 6) ? 8'h00 : 8'h01);
      end
   endtask
   task automatic t_ports;
      logic [7:0] q;
      @(posedge mclk);
      port_a_pins_in <= 8'ha5;
      rx_pin <= 1'b0;
      bus(1'b0, 1'b0, ADDR_OUTPUT_PORT_CONFIG, 8'hff, q);
      bus(1'b0, 1'b0, ADDR_PFC, 8'h04, q);
      repeat (2) @(posedge mclk);
      chk(port_a_pins_oe_n, 8'h04);
      chk(port_a_pins_out, 8'h38);
      chk({3'h0, port_b_pins_oe_n}, 8'h00);
      chk({3'h0, port_b_pins_out}, 8'h1c);
      timer_ready_flag <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(port_a_pins_oe_n, 8'h00);
      // Port A now drives, so the low space read must float it
      bus(1'b1, 1'b0, 7'h05, 8'h00, q);
      chk(q, 8'h00);
      bus(1'b1, 1'b0, ADDR_PORTA_IN, 8'h00, q);
      chk(q, 8'ha5);
      chk({7'h0, rx_bit}, 8'h00);
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      reset = 1'b1;
      {tx_serial_bit, tx_active, tx_enable, local_loopback, rx_pin} = 5'h01;
      irq_sources = 11'h000;
      {receive_ready_flag, transmit_ready_flag, timer_ready_flag} = 3'h0;
      port_a_pins_in = 8'h00;
      port_b_pins_in = 5'h00;
      errors = 0;
      checks = 0;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      t_reset();
      t_regs();
      t_irq();
      t_tx();
      t_ports();
      // Second reset with written registers shows the clear really happens
      @(posedge mclk);
      reset <= 1'b1;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      t_reset();
      summarize();
   end
endmodule // tb_top
bind host_bus_ctrl host_bus_ctrl_asserts i_host_bus_ctrl_asserts (.mclk, .reset, .chip_select_n,
   .interrupt_ack_n, .register_select_lines, .data_oe_n, .transfer_ack_n, .transfer_ack_oe_n,
   .interrupt_request_n, .interrupt_request_oe_n, .tx_serial_bit, .tx_active, .tx_enable, .local_loopback,
   .rx_pin, .tx_pin, .rx_bit, .timer_run, .mode_pointer_out, .port_a_pins_oe_n, .baud_sel_out,
   .port_b_pins_oe_n);
